/* logic/ufc_pkg.sv */
// Constants shared by the flow-controlled UART block.
// Assumes register word index = Avalon byte address / 4.
package ufc_pkg;
    localparam int UFC_FIFO_DEPTH = 64;
    // Register word indices
    localparam logic [5:0] UFC_A_DATA  = 6'h00;
    localparam logic [5:0] UFC_A_IER   = 6'h01;
    localparam logic [5:0] UFC_A_ISR   = 6'h02;
    localparam logic [5:0] UFC_A_FCR   = 6'h03;
    localparam logic [5:0] UFC_A_LCR   = 6'h04;
    localparam logic [5:0] UFC_A_MCR   = 6'h05;
    localparam logic [5:0] UFC_A_LSR   = 6'h06;
    localparam logic [5:0] UFC_A_EFR   = 6'h07;
    localparam logic [5:0] UFC_A_TCR   = 6'h08;
    localparam logic [5:0] UFC_A_EXTENDED_CONTROL  = 6'h09;
    localparam logic [5:0] UFC_A_RESUME_CHAR_FIRST  = 6'h0a;
    localparam logic [5:0] UFC_A_XON2  = 6'h0b;
    localparam logic [5:0] UFC_A_XOFF1 = 6'h0c;
    localparam logic [5:0] UFC_A_STOP_CHAR_SECOND = 6'h0d;
    localparam logic [5:0] UFC_A_DIV   = 6'h0e;
    localparam logic [5:0] UFC_A_TRIG  = 6'h0f;
    // Field positions
    localparam int UFC_IER_RX    = 0;
    localparam int UFC_IER_TX    = 1;
    localparam int UFC_IER_XOFF  = 5;
    localparam int UFC_IER_RTS   = 6;
    localparam int UFC_IER_CTS   = 7;
    localparam int UFC_EFR_ENH   = 4;
    localparam int UFC_EFR_SPEC  = 5;
    localparam int UFC_EFR_ARTS  = 6;
    localparam int UFC_EFR_ACTS  = 7;
    localparam int UFC_EXTENDED_CONTROL_485  = 4;
    localparam int UFC_EXTENDED_CONTROL_INV  = 5;
    localparam int UFC_MCR_RTS   = 1;
    localparam int UFC_FCR_EN    = 0;
    localparam int UFC_LCR_PEN   = 3;
    localparam int UFC_LCR_EVEN  = 4;
    localparam int UFC_LSR_THRE  = 5;
    localparam int UFC_LSR_TEMT  = 6;
    // Timing
    localparam logic [4:0] UFC_OS16     = 5'h10;
    localparam int         UFC_MIN_WL   = 5;
    localparam int         UFC_TO_WORDS = 4;
    localparam int         UFC_TO_EXTRA = 12;
    localparam int         UFC_TCR_SHIFT = 2;
    localparam logic [15:0] UFC_DIV_RST = 16'h0001;
    typedef enum logic [2:0] {
        UFC_IDLE, UFC_START, UFC_DATA, UFC_PAR, UFC_STOP
    } ufc_bit_t;
endpackage : ufc_pkg

/* logic/ufc_uart.sv */
// UART with 64-deep FIFOs, hardware and software flow control.
// Assumes an Avalon-MM master and synchronous serial inputs.
// Function
// RULE1 - FIFO mode takes 64 tx bytes; holding-empty flag set when FIFO empty
// RULE2 - Tx-empty interrupt, status bit 1, when fill drops below trigger
// RULE3 - Transmitter-empty flag only when shifter and FIFO both empty
// RULE4 - Start bit sampled at half bit after falling edge, must be low
// RULE5 - Data, parity, stop sampled at centre; errors in status bits 2-4
// RULE6 - Receive FIFO is 64 entries of 8 data plus 3 error tags
// RULE7 - Reading rx holding advances FIFO and updates tags at once
// RULE8 - Rx ready interrupt per character or at trigger, enable bit 0
// RULE9 - Timeout interrupt after 4 word lengths plus 12 bits idle
// RULE10 - Auto RTS by feature bit 6, started by modem-control RTS bit
// RULE11 - RTS low-to-high sets status bit 5 when enable bit 6 set
// RULE12 - Auto RTS off at halt level, on again at resume level
// RULE13 - Host keeps halt level above resume level
// RULE14 - Auto CTS: finish current character, suspend, flag bit 5
// RULE15 - Xoff match halts tx after current char, sets flag if enabled
// RULE16 - Xon match resumes transmission and clears status bit 4
// RULE17 - Flow character registers power up zero, survive reset
// RULE18 - Double mode matches two chars; flow chars never stored
// RULE19 - Send Xoff at halt level and Xon at resume level
// RULE20 - Special character matching second Xoff stored, sets bit 4
// RULE21 - Comparisons use only the programmed word length bits
// RULE22 - RS-485: RTS idle high, low while sending, invertible
// RULE23 - Writes to a full tx FIFO are discarded
`timescale 1ns/1ps
module ufc_uart
    import ufc_pkg::*;
#(
    parameter int DEPTH = UFC_FIFO_DEPTH,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        rxd,
    output logic             txd,
    input  wire logic        cts_n,
    output logic             rts_n,
    output logic             irq
);
    typedef struct packed {
        logic                   ack;
        logic [31:0]            rdata;
        logic [DEPTH-1:0][7:0]  txm;
        logic [AW-1:0]          txw;
        logic [AW-1:0]          txr;
        logic [AW:0]            txc;
        logic [DEPTH-1:0][10:0] rxm;
        logic [AW-1:0]          rxw;
        logic [AW-1:0]          rxr;
        logic [AW:0]            rxc;
        logic [7:0]             interrupt_enable, fifo_control, line_control, modem_control, enhanced_feature, flow_level_control, extended_control;
        logic [7:0]             resume_char_first, xon2, xoff1, stop_char_second;
        logic [7:0]             txtrig, rxtrig;
        logic [15:0]            div;
        logic [1:0]             osm;
        logic [15:0]            dcnt;
        ufc_bit_t               tst;
        logic [7:0]             tsh;
        logic [2:0]             tbit;
        logic [3:0]             ttk;
        logic                   tpar;
        logic                   txd;
        ufc_bit_t               rsm;
        logic [7:0]             rsh;
        logic [2:0]             rbit;
        logic [3:0]             rtk;
        logic                   rpe;
        logic                   rprev;
        logic [10:0]            tocnt;
        logic                   xoff_rx, xoff_sent, fc_xon;
        logic [1:0]             fc_cnt;
        logic                   half, half_on;
        logic                   rts_hold, rts_n, cts_prev;
        logic                   isr4, isr5, ovr, irq;
    } ufc_state_t;

    ufc_state_t s_q = '0;
    ufc_state_t n;

    logic [5:0]  idx;
    logic        acc, rd_acc, wr_acc, tick;
    logic [4:0]  os, half;
    logic [2:0]  nb;
    logic [7:0]  mask, c;
    logic [10:0] hd, lim;
    logic [AW:0] cap, halt, resume;
    logic [7:0]  isrv, lsrv, rdv, fcsel;
    logic        txint, rxint, to, susp, act;
    logic        tpush, tpop, rpush, rpop, rdone, flow;

    assign idx    = avs_address[7:2];
    assign acc    = (avs_read | avs_write) & s_q.ack;
    assign rd_acc = acc & avs_read;
    assign wr_acc = acc & avs_write;
    assign tick   = s_q.dcnt == 16'h0000;
    assign os     = UFC_OS16 >> s_q.osm;
    assign half   = os >> 1;
    assign nb     = 3'(UFC_MIN_WL - 1) + {1'b0, s_q.line_control[1:0]};
    assign mask   = 8'hff >> (2'h3 - s_q.line_control[1:0]); // RULE21
    assign hd     = s_q.rxm[s_q.rxr];
    assign lim    = 11'(UFC_TO_WORDS * (UFC_MIN_WL + s_q.line_control[1:0])
                    + UFC_TO_EXTRA) * 11'(os); // RULE9
    assign cap    = s_q.fifo_control[UFC_FCR_EN] ? (AW+1)'(DEPTH) : (AW+1)'(1);
    assign halt   = (AW+1)'(s_q.flow_level_control[3:0]) << UFC_TCR_SHIFT;
    assign resume = (AW+1)'(s_q.flow_level_control[7:4]) << UFC_TCR_SHIFT;
    assign txint  = s_q.fifo_control[UFC_FCR_EN] ? s_q.txc < (AW+1)'(s_q.txtrig)
                    : s_q.txc == '0; // RULE2
    assign rxint  = s_q.rxc != '0 && (!s_q.fifo_control[UFC_FCR_EN] ||
                    s_q.rxc >= (AW+1)'(s_q.rxtrig)); // RULE8
    assign to     = s_q.rxc != '0 && s_q.tocnt >= lim; // RULE9
    assign susp   = (s_q.enhanced_feature[UFC_EFR_ACTS] & cts_n) | s_q.xoff_rx;
    assign act    = s_q.txc != '0 || s_q.tst != UFC_IDLE || s_q.fc_cnt != '0;
    assign isrv   = {2'h0, s_q.isr5, s_q.isr4, 1'b0, to, txint, rxint};
    assign lsrv   = {1'b0,
                     s_q.txc == '0 && s_q.tst == UFC_IDLE, // RULE3
                     s_q.txc == '0, // RULE1
                     s_q.rxc != '0 ? hd[10:8] : 3'h0, // RULE5
                     s_q.ovr, s_q.rxc != '0};
    assign fcsel  = (s_q.enhanced_feature[3:2] == 2'h2 ||
                    (s_q.enhanced_feature[3:2] == 2'h3 && s_q.fc_cnt == 2'h1))
                    ? (s_q.fc_xon ? s_q.xon2 : s_q.stop_char_second)
                    : (s_q.fc_xon ? s_q.resume_char_first : s_q.xoff1);

    always_comb begin
        case (idx)
            UFC_A_DATA:  rdv = hd[7:0];
            UFC_A_IER:   rdv = s_q.interrupt_enable;
            UFC_A_ISR:   rdv = isrv;
            UFC_A_FCR:   rdv = s_q.fifo_control;
            UFC_A_LCR:   rdv = s_q.line_control;
            UFC_A_MCR:   rdv = s_q.modem_control;
            UFC_A_LSR:   rdv = lsrv;
            UFC_A_EFR:   rdv = s_q.enhanced_feature;
            UFC_A_TCR:   rdv = s_q.flow_level_control;
            UFC_A_EXTENDED_CONTROL:  rdv = s_q.extended_control;
            UFC_A_RESUME_CHAR_FIRST:  rdv = s_q.resume_char_first;
            UFC_A_XON2:  rdv = s_q.xon2;
            UFC_A_XOFF1: rdv = s_q.xoff1;
            UFC_A_STOP_CHAR_SECOND: rdv = s_q.stop_char_second;
            default:     rdv = 8'h00;
        endcase
    end

    always_comb begin
        n     = s_q;
        tpush = 1'b0;
        tpop  = 1'b0;
        rpush = 1'b0;
        rpop  = 1'b0;
        rdone = 1'b0;
        flow  = 1'b0;
        c     = s_q.rsh & mask;
        n.ack = (avs_read | avs_write) & ~s_q.ack;
        if (avs_read & ~s_q.ack) begin
            case (idx)
                UFC_A_DIV:  n.rdata = {14'h0, s_q.osm, s_q.div};
                UFC_A_TRIG: n.rdata = {16'h0, s_q.rxtrig, s_q.txtrig};
                default:    n.rdata = {24'h0, rdv};
            endcase
        end
        n.dcnt = tick ? (s_q.div == '0 ? '0 : s_q.div - 16'h0001)
                      : s_q.dcnt - 16'h0001;
        // Host side: clears first so that same-cycle events win
        if (rd_acc) begin
            if (idx == UFC_A_DATA && s_q.rxc != '0) begin
                rpop  = 1'b1; // RULE7
                n.rxr = s_q.rxr + 1'b1;
            end
            if (idx == UFC_A_ISR) begin
                n.isr4 = 1'b0;
                n.isr5 = 1'b0;
            end
            if (idx == UFC_A_LSR)
                n.ovr = 1'b0;
        end
        if (wr_acc && avs_byteenable[0]) begin
            case (idx)
                UFC_A_DATA: if (s_q.txc < cap) begin // RULE23
                    n.txm[s_q.txw] = avs_writedata[7:0]; // RULE1
                    n.txw = s_q.txw + 1'b1;
                    tpush = 1'b1;
                end
                UFC_A_IER: n.interrupt_enable = s_q.enhanced_feature[UFC_EFR_ENH] ? avs_writedata[7:0]
                    : {s_q.interrupt_enable[7:4], avs_writedata[3:0]}; // RULE11
                UFC_A_FCR:   n.fifo_control   = avs_writedata[7:0];
                UFC_A_LCR:   n.line_control   = avs_writedata[7:0];
                UFC_A_MCR:   n.modem_control   = avs_writedata[7:0]; // RULE10
                UFC_A_EFR:   n.enhanced_feature   = avs_writedata[7:0];
                UFC_A_TCR:   n.flow_level_control   = avs_writedata[7:0];
                UFC_A_EXTENDED_CONTROL:  n.extended_control  = avs_writedata[7:0];
                UFC_A_RESUME_CHAR_FIRST:  n.resume_char_first  = avs_writedata[7:0];
                UFC_A_XON2:  n.xon2  = avs_writedata[7:0];
                UFC_A_XOFF1: n.xoff1 = avs_writedata[7:0];
                UFC_A_STOP_CHAR_SECOND: n.stop_char_second = avs_writedata[7:0];
                UFC_A_DIV:   n.div[7:0] = avs_writedata[7:0];
                UFC_A_TRIG:  n.txtrig = avs_writedata[7:0];
                default: ;
            endcase
        end
        if (wr_acc && avs_byteenable[1] && idx == UFC_A_DIV)
            n.div[15:8] = avs_writedata[15:8];
        if (wr_acc && avs_byteenable[1] && idx == UFC_A_TRIG)
            n.rxtrig = avs_writedata[15:8];
        if (wr_acc && avs_byteenable[2] && idx == UFC_A_DIV)
            n.osm = avs_writedata[17:16];
        // Receiver, one step per oversampling tick
        if (tick) begin
            n.rprev = rxd;
            case (s_q.rsm)
                UFC_IDLE: if (s_q.rprev && !rxd) begin
                    n.rsm = UFC_START;
                    n.rtk = '0;
                end
                UFC_START: if (s_q.rtk == 4'(half - 5'h01)) begin
                    n.rtk  = '0;
                    n.rbit = '0;
                    n.rsh  = '0;
                    n.rpe  = 1'b0;
                    n.rsm  = rxd ? UFC_IDLE : UFC_DATA; // RULE4
                end else
                    n.rtk = s_q.rtk + 4'h1;
                UFC_DATA: if (s_q.rtk == 4'(os - 5'h01)) begin
                    n.rtk = '0;
                    n.rsh[s_q.rbit] = rxd; // RULE5
                    n.rbit = s_q.rbit + 3'h1;
                    if (s_q.rbit == nb)
                        n.rsm = s_q.line_control[UFC_LCR_PEN] ? UFC_PAR : UFC_STOP;
                end else
                    n.rtk = s_q.rtk + 4'h1;
                UFC_PAR: if (s_q.rtk == 4'(os - 5'h01)) begin
                    n.rtk = '0;
                    n.rpe = rxd ^ (^c) ^ ~s_q.line_control[UFC_LCR_EVEN]; // RULE5
                    n.rsm = UFC_STOP;
                end else
                    n.rtk = s_q.rtk + 4'h1;
                UFC_STOP: if (s_q.rtk == 4'(os - 5'h01)) begin
                    rdone = 1'b1;
                    n.rsm = UFC_IDLE;
                end else
                    n.rtk = s_q.rtk + 4'h1;
                default: n.rsm = UFC_IDLE;
            endcase
        end
        // Received character: flow matching, special detect, store
        if (rdone) begin
            case (s_q.enhanced_feature[1:0])
                2'h1, 2'h2: begin
                    if (c == ((s_q.enhanced_feature[1] ? s_q.xon2 : s_q.resume_char_first) & mask)) begin
                        flow = 1'b1;
                        n.xoff_rx = 1'b0; // RULE16
                        n.isr4 = 1'b0;
                    end else if (c == ((s_q.enhanced_feature[1] ? s_q.stop_char_second : s_q.xoff1)
                                 & mask)) begin
                        flow = 1'b1;
                        n.xoff_rx = 1'b1; // RULE15
                        n.isr4 = s_q.isr4 | s_q.interrupt_enable[UFC_IER_XOFF];
                    end
                end
                2'h3: if (s_q.half) begin // RULE18
                    n.half = 1'b0;
                    if (s_q.half_on && c == (s_q.xon2 & mask)) begin
                        flow = 1'b1;
                        n.xoff_rx = 1'b0;
                        n.isr4 = 1'b0;
                    end else if (!s_q.half_on && c == (s_q.stop_char_second & mask)) begin
                        flow = 1'b1;
                        n.xoff_rx = 1'b1;
                        n.isr4 = s_q.isr4 | s_q.interrupt_enable[UFC_IER_XOFF];
                    end
                end else if (c == (s_q.resume_char_first & mask) ||
                             c == (s_q.xoff1 & mask)) begin
                    flow = 1'b1;
                    n.half = 1'b1;
                    n.half_on = c == (s_q.resume_char_first & mask);
                end
                default: ;
            endcase
            if (!flow) begin
                if (s_q.enhanced_feature[UFC_EFR_SPEC] && c == (s_q.stop_char_second & mask))
                    n.isr4 = 1'b1; // RULE20
                if (s_q.rxc < (AW+1)'(DEPTH)) begin
                    n.rxm[s_q.rxw] = {c == 8'h00 && !rxd, !rxd, s_q.rpe, c};
                    n.rxw = s_q.rxw + 1'b1; // RULE6
                    rpush = 1'b1;
                end else
                    n.ovr = 1'b1;
            end
        end
        if (rpush || rpop || s_q.rsm != UFC_IDLE || s_q.rxc == '0)
            n.tocnt = '0;
        else if (tick && s_q.tocnt < lim)
            n.tocnt = s_q.tocnt + 11'h001; // RULE9
        // Transmitter
        if (tick) begin
            if (s_q.tst == UFC_IDLE) begin
                if (s_q.fc_cnt != '0) begin
                    n.tsh = fcsel; // RULE19
                    n.fc_cnt = s_q.fc_cnt - 2'h1;
                    n.tst = UFC_START;
                end else if (s_q.txc != '0 && !susp) begin // RULE14 RULE15
                    n.tsh = s_q.txm[s_q.txr];
                    n.txr = s_q.txr + 1'b1;
                    tpop  = 1'b1;
                    n.tst = UFC_START;
                end
                n.txd  = n.tst == UFC_IDLE;
                n.ttk  = '0;
                n.tbit = '0;
                n.tpar = 1'b0;
            end else if (s_q.ttk != 4'(os - 5'h01))
                n.ttk = s_q.ttk + 4'h1;
            else begin
                n.ttk = '0;
                case (s_q.tst)
                    UFC_START: begin
                        n.tst = UFC_DATA;
                        n.txd = s_q.tsh[0];
                    end
                    UFC_DATA: begin
                        n.tpar = s_q.tpar ^ s_q.tsh[0];
                        n.tsh  = s_q.tsh >> 1;
                        n.tbit = s_q.tbit + 3'h1;
                        n.txd  = s_q.tsh[1];
                        if (s_q.tbit == nb) begin
                            n.tst = s_q.line_control[UFC_LCR_PEN] ? UFC_PAR : UFC_STOP;
                            n.txd = s_q.line_control[UFC_LCR_PEN]
                                  ? n.tpar ^ ~s_q.line_control[UFC_LCR_EVEN] : 1'b1;
                        end
                    end
                    UFC_PAR: begin
                        n.tst = UFC_STOP;
                        n.txd = 1'b1;
                    end
                    default: begin
                        n.tst = UFC_IDLE;
                        n.txd = 1'b1;
                    end
                endcase
            end
        end
        n.txc = s_q.txc + (AW+1)'(tpush) - (AW+1)'(tpop);
        n.rxc = s_q.rxc + (AW+1)'(rpush) - (AW+1)'(rpop);
        // Flow characters sent on our own receive level
        if (s_q.enhanced_feature[3:2] != 2'h0 && s_q.fc_cnt == '0) begin
            if (!s_q.xoff_sent && s_q.rxc >= halt) begin
                n.fc_cnt = s_q.enhanced_feature[3:2] == 2'h3 ? 2'h2 : 2'h1; // RULE19
                n.fc_xon = 1'b0;
                n.xoff_sent = 1'b1;
            end else if (s_q.xoff_sent && s_q.rxc <= resume) begin
                n.fc_cnt = s_q.enhanced_feature[3:2] == 2'h3 ? 2'h2 : 2'h1;
                n.fc_xon = 1'b1;
                n.xoff_sent = 1'b0;
            end
        end
        if (s_q.rxc >= halt)
            n.rts_hold = 1'b1; // RULE12
        else if (s_q.rxc <= resume)
            n.rts_hold = 1'b0;
        if (s_q.extended_control[UFC_EXTENDED_CONTROL_485])
            n.rts_n = ~act ^ s_q.extended_control[UFC_EXTENDED_CONTROL_INV]; // RULE22
        else
            n.rts_n = ~(s_q.modem_control[UFC_MCR_RTS] &
                      ~(s_q.enhanced_feature[UFC_EFR_ARTS] & n.rts_hold)); // RULE10 RULE12
        if (!s_q.rts_n && n.rts_n && s_q.interrupt_enable[UFC_IER_RTS])
            n.isr5 = 1'b1; // RULE11
        n.cts_prev = cts_n;
        if (s_q.enhanced_feature[UFC_EFR_ACTS] && cts_n && !s_q.cts_prev &&
            s_q.interrupt_enable[UFC_IER_CTS])
            n.isr5 = 1'b1; // RULE14
        n.irq = ((rxint | to) & s_q.interrupt_enable[UFC_IER_RX]) |
                (txint & s_q.interrupt_enable[UFC_IER_TX]) | s_q.isr4 | s_q.isr5;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q          <= '0;
            s_q.div      <= UFC_DIV_RST;
            s_q.txd      <= 1'b1;
            s_q.rts_n    <= 1'b1;
            s_q.rprev    <= 1'b1;
            s_q.cts_prev <= 1'b1;
            s_q.resume_char_first     <= s_q.resume_char_first; // RULE17
            s_q.xon2     <= s_q.xon2;
            s_q.xoff1    <= s_q.xoff1;
            s_q.stop_char_second    <= s_q.stop_char_second;
        end else
            s_q <= n;
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
    assign avs_readdata    = s_q.rdata;
    assign txd             = s_q.txd;
    assign rts_n           = s_q.rts_n;
    assign irq             = s_q.irq;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    tx_push_a: assert property (wr_acc && avs_byteenable[0] && // RULE1
        idx == UFC_A_DATA && s_q.txc < cap && !tpop
        |=> s_q.txc == $past(s_q.txc) + 1'b1)
        else $error("tx write not stored");
    tx_full_drop_a: assert property (tpush |-> s_q.txc < cap) // RULE23
        else $error("write stored into full tx fifo");
    temt_flag_a: assert property (s_q.tst != UFC_IDLE // RULE3
        |-> !lsrv[UFC_LSR_TEMT]) else $error("temt while shifting");
    start_reject_a: assert property (tick && s_q.rsm == UFC_START && // RULE4
        s_q.rtk == 4'(half - 5'h01) && rxd |=> s_q.rsm == UFC_IDLE)
        else $error("false start accepted");
    rx_pop_a: assert property (rpop && !rpush // RULE7
        |=> s_q.rxc == $past(s_q.rxc) - 1'b1) else $error("rx pop lost");
    rx_depth_a: assert property (s_q.rxc <= (AW+1)'(DEPTH)) // RULE6
        else $error("rx fifo overcount");
    timeout_a: assert property (s_q.rxc == '0 |-> !to) // RULE9
        else $error("timeout with empty fifo");
    rts_halt_a: assert property (s_q.enhanced_feature[UFC_EFR_ARTS] && // RULE12
        s_q.modem_control[UFC_MCR_RTS] && !s_q.extended_control[UFC_EXTENDED_CONTROL_485] &&
        s_q.rxc >= halt |=> s_q.rts_n) else $error("rts not halted");
    cts_hold_a: assert property (s_q.tst == UFC_IDLE && // RULE14
        s_q.enhanced_feature[UFC_EFR_ACTS] && cts_n && s_q.fc_cnt == '0
        |=> s_q.tst == UFC_IDLE) else $error("sent while cts off");
    xoff_hold_a: assert property (s_q.tst == UFC_IDLE && // RULE15
        s_q.xoff_rx && s_q.fc_cnt == '0 |=> s_q.tst == UFC_IDLE)
        else $error("sent while xoff");
    rs485_dir_a: assert property (s_q.extended_control[UFC_EXTENDED_CONTROL_485] && // RULE22
        !s_q.extended_control[UFC_EXTENDED_CONTROL_INV] && s_q.tst != UFC_IDLE |=> !s_q.rts_n)
        else $error("rs485 rts not driving");

    tx_frame_c: cover property (s_q.tst == UFC_STOP ##1 s_q.tst == UFC_IDLE);
    rx_store_c: cover property (rpush);
    xoff_c:     cover property (!s_q.xoff_rx ##1 s_q.xoff_rx);
    timeout_c:  cover property (!to ##1 to);
endmodule : ufc_uart

/* verif/ufc_peer.sv */
// Remote serial end: sends frames on rxd, collects frames seen on txd.
// Assumes 16 clk_sys cycles per bit (divisor 1, 16x), 8N1 framing.
`timescale 1ns/1ps
module ufc_peer (
    input  wire logic clk_sys,
    input  wire logic txd,
    output logic      rxd
);
    logic [7:0] got_q[$];
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (16) @(posedge clk_sys);
        end
    endtask : send
    // Low glitch shorter than half a bit
    task automatic pulse(input int n);
        rxd <= 1'b0;
        repeat (n) @(posedge clk_sys);
        rxd <= 1'b1;
    endtask : pulse
    initial begin
        logic [7:0] b;
        rxd = 1'b1;
        forever begin
            @(negedge txd);
            repeat (8) @(posedge clk_sys);
            for (int i = 0; i < 8; i++) begin
                repeat (16) @(posedge clk_sys);
                b[i] = txd;
            end
            repeat (16) @(posedge clk_sys);
            got_q.push_back(b);
        end
    end
endmodule : ufc_peer

/* verif/uart_fifo_rx_flow_control_test.sv */
// Self-checking bench for ufc_uart against a remote serial peer.
// Assumes divisor 1 and 16x oversampling as left by reset.
`timescale 1ns/1ps
module uart_fifo_rx_flow_control_test;
    import ufc_pkg::*;
    logic        clk_sys, rst, rd, wr, rxd, txd, cts_n, rts_n, irq, wait_r;
    logic [3:0]  be;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, got, seed;
    logic [7:0]  exp_q[$];
    int          fail_count, checks;
    ufc_uart dut (.clk_sys(clk_sys), .rst(rst), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_byteenable(be),
        .avs_writedata(wdat), .avs_readdata(rdat),
        .avs_waitrequest(wait_r), .rxd(rxd), .txd(txd), .cts_n(cts_n),
        .rts_n(rts_n), .irq(irq));
    ufc_peer peer (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [7:0] d);
        @(posedge clk_sys);
        adr <= {a, 2'b00};
        wdat <= {24'h0, d};
        be <= 4'hf;
        wr <= w;
        rd <= ~w;
        // Look at waitrequest mid-cycle, then complete on the next edge
        do @(negedge clk_sys); while (wait_r !== 1'b0);
        @(posedge clk_sys);
        got = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic chk(input string nm, input logic [7:0] e, s);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (8000) @(posedge clk_sys);
        fail_count++;
        summarize();
    end
    initial begin
        {rst, rd, wr, cts_n} = 4'h8;
        be = 4'hf;
        adr = 8'h00;
        wdat = 32'h0;
        seed = 32'h00018613;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        bus(1'b0, UFC_A_LSR, 8'h00);
        chk("lsr idle", 8'h60, got[7:0]);
        bus(1'b0, 6'h10, 8'h00);
        chk("unmapped", 8'h00, got[7:0]);
        bus(1'b1, UFC_A_FCR, 8'h01);
        bus(1'b1, UFC_A_LCR, 8'h03);
        bus(1'b1, UFC_A_TCR, 8'h24);
        bus(1'b1, UFC_A_TRIG, 8'h02);
        bus(1'b1, UFC_A_IER, 8'h02);
        repeat (4) begin
            seed = nxt(seed);
            exp_q.push_back(seed[7:0]);
            bus(1'b1, UFC_A_DATA, seed[7:0]);
        end
        bus(1'b0, UFC_A_LSR, 8'h00);
        chk("lsr busy", 8'h00, got[7:0] & 8'h60);
        chk("irq above trig", 8'h00, {7'h0, irq});
        while (peer.got_q.size() < 4) @(posedge clk_sys);
        repeat (32) @(posedge clk_sys);
        for (int i = 0; i < 4; i++)
            chk("tx byte", exp_q[i], peer.got_q[i]);
        bus(1'b0, UFC_A_LSR, 8'h00);
        chk("lsr drained", 8'h60, got[7:0]);
        chk("irq below trig", 8'h01, {7'h0, irq});
        $display("test tx done");
        bus(1'b1, UFC_A_IER, 8'h01);
        exp_q = {};
        repeat (3) begin
            seed = nxt(seed);
            exp_q.push_back(seed[7:0]);
            peer.send(seed[7:0]);
        end
        chk("irq rx", 8'h01, {7'h0, irq});
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, UFC_A_DATA, 8'h00);
            chk("rx byte", exp_q[i], got[7:0]);
        end
        bus(1'b0, UFC_A_LSR, 8'h00);
        chk("lsr rx empty", 8'h00, got[7:0] & 8'h1f);
        peer.pulse(int'(seed[1:0]) + 4);
        repeat (300) @(posedge clk_sys);
        bus(1'b0, UFC_A_LSR, 8'h00);
        chk("false start", 8'h00, got[7:0] & 8'h01);
        $display("test rx done");
        bus(1'b1, UFC_A_XOFF1, 8'h13);
        bus(1'b1, UFC_A_RESUME_CHAR_FIRST, 8'h11);
        bus(1'b1, UFC_A_EFR, 8'h11);
        bus(1'b1, UFC_A_IER, 8'h20);
        peer.send(8'h13);
        repeat (4) @(posedge clk_sys);
        chk("irq xoff", 8'h01, {7'h0, irq});
        bus(1'b1, UFC_A_DATA, 8'h5a);
        repeat (400) @(posedge clk_sys);
        chk("tx held", 8'h04, 8'(peer.got_q.size()));
        peer.send(8'h11);
        repeat (4) @(posedge clk_sys);
        chk("irq xon", 8'h00, {7'h0, irq});
        while (peer.got_q.size() < 5) @(posedge clk_sys);
        chk("resumed", 8'h5a, peer.got_q[4]);
        bus(1'b0, UFC_A_LSR, 8'h00);
        chk("flow not stored", 8'h00, got[7:0] & 8'h01);
        $display("test flow done");
        summarize();
    end
endmodule : uart_fifo_rx_flow_control_test
